// [protect_irq_regs.svh]
// Register offsets, bit positions and fixed codes of the irq block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef PROTECT_IRQ_REGS_SVH
`define PROTECT_IRQ_REGS_SVH

// Register offsets on the serial control bus
`define OFF_IRQ_ENABLE 8'hc6
`define OFF_IRQ_STATUS 8'hc7
`define OFF_IDENT_0    8'hf0
`define OFF_IDENT_1    8'hf1
`define OFF_IDENT_2    8'hf2
`define OFF_IDENT_3    8'hf3
`define OFF_IDENT_4    8'hf4
`define OFF_IDENT_5    8'hf5

// Reset values
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_STATUS 7'h00

// Bit 0 of both registers is the global bit; bits 7:1 are the sources
`define GLOBAL_BIT     0

// Identification codes; values are arbitrary
`define IDENT_0        8'h61
`define IDENT_1        8'h62
`define IDENT_2_YES    8'h63
`define IDENT_2_NO     8'h64
`define IDENT_3        8'h66
`define IDENT_4        8'h67
`define IDENT_5        8'h68
`define IDENT_NONE     8'h00

// Serial bus framing and default target address (value arbitrary)
`define BYTE_BITS      4'h8
`define LAST_TX_BIT    4'h7
`define DEV_ADDR       7'h2c

`endif

// [protect_irq_pkg.sv]
// Types shared by the content-protection interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package protect_irq_pkg;

  // Single-cycle events from the authentication engine
  typedef struct packed {
    logic indirect_done;
    logic key_list_ready;
    logic rx_key_ready;
    logic auth_fail;
    logic auth_ok;
  } protect_events_type;

  // Sticky flags, ordered as status bits 7 down to 1
  typedef struct packed {
    logic indirect_done;
    logic rx_found;
    logic remote_irq;
    logic key_list_ready;
    logic rx_key_ready;
    logic auth_fail;
    logic auth_ok;
  } status_flags_type;

  // Serial bus target states, one-hot
  typedef enum logic [5:0] {
    BUS_IDLE  = 6'b000001,
    BUS_ADDR  = 6'b000010,
    BUS_ACK   = 6'b000100,
    BUS_RX    = 6'b001000,
    BUS_TX    = 6'b010000,
    BUS_TXACK = 6'b100000
  } bus_state_type;

endpackage

// [pin_filter.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_filter #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Pins in, filtered levels out
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);
  logic [WIDTH-1:0] stage1_reg, stage2_reg, stage3_reg, clean_reg;
  logic [WIDTH-1:0] clean_next;

  // Stage one feeds only stage two, so it never reaches decision logic
  always_comb begin
    clean_next = clean_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2_reg[i] == stage3_reg[i]) begin
        clean_next[i] = stage3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
      stage3_reg <= INIT;
      clean_reg  <= INIT;
    end else begin
      stage1_reg <= raw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      clean_reg  <= clean_next;
    end
  end

  assign clean = clean_reg;
endmodule

// [ident_rom.sv]
// Read-only identification bytes with registered read data.
// Assumes the address is held stable for a cycle before use.
`timescale 1ns/1ps
`include "protect_irq_regs.svh"
module ident_rom #(
  parameter logic CAPABLE = 1'b1
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Lookup
  input  wire logic [7:0] addr,
  output logic      [7:0] data
);
  logic [7:0] data_reg, data_next;

  // Third byte tells whether content protection is fitted
  always_comb begin
    unique case (addr)
      `OFF_IDENT_0: data_next = `IDENT_0;
      `OFF_IDENT_1: data_next = `IDENT_1;
      `OFF_IDENT_2: data_next = CAPABLE ? `IDENT_2_YES : `IDENT_2_NO;
      `OFF_IDENT_3: data_next = `IDENT_3;
      `OFF_IDENT_4: data_next = `IDENT_4;
      `OFF_IDENT_5: data_next = `IDENT_5;
      default:      data_next = `IDENT_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      data_reg <= `IDENT_NONE;
    end else begin
      data_reg <= data_next;
    end
  end

  assign data = data_reg;
endmodule

// [content_protect_irq_ctrl.sv]
// Content-protection interrupt enable/status block with serial bus target.
// Assumes event pulses come from logic on clk; bus pins and the remote
// interrupt pin are asynchronous and are filtered here.
// Function
// - Enable bit 7 lets indirect access completion raise an interrupt.
// - Enable bit 6: receiver detect, held until lock if selected.
// - Enable bit 5 lets a forwarded receiver interrupt reach the host.
// - Enable bit 4 lets key list ready raise an interrupt.
// - Enable bit 3 lets receiver key ready raise an interrupt.
// - Enable bit 2 covers authentication failure and later loss.
// - Enable bit 1 lets authentication pass raise an interrupt.
// - Enable bit 0 globally gates the interrupt output.
// - Status bit 7 shows indirect access completed.
// - Status bit 6 shows a downstream receiver was detected.
// - Status bit 5 shows a forwarded downstream interrupt request.
// - Status bit 4 shows the key list is ready to read.
// - Status bit 3 shows the receiver key is ready to read.
// - Status bit 2 shows authentication failed or was lost.
// - Status bit 1 shows authentication passed.
// - Status bit 0 is the OR of all enabled status flags.
// - Six read-only ident bytes; third byte tells protection support.
// - Remote interrupt pin is active low; zero means pending.
`timescale 1ns/1ps
`include "protect_irq_regs.svh"
module content_protect_irq_ctrl
  import protect_irq_pkg::*;
#(
  parameter logic PROTECT_CAPABLE = 1'b1
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Serial control bus pins, open drain
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // Authentication engine events and levels
  input  wire protect_events_type event_pulse,
  input  wire logic               rx_detect,
  input  wire logic               rx_lock,
  input  wire logic               detect_waits_for_lock_sel,
  // Remote receiver interrupt pin
  input  wire logic               remote_irq_in_n,
  // Interrupt to the controller
  output logic                    irq_n_out
);
  logic [2:0]       pins_clean;
  logic             scl_c, sda_c, remote_c;
  logic [7:0]       rom_data, rd_data, status_byte;
  bus_state_type    state_reg, state_next;
  logic [3:0]       cnt_reg, cnt_next;
  logic [7:0]       shift_reg, shift_next, ptr_reg, ptr_next;
  logic             rw_reg, rw_next, first_reg, first_next;
  logic             nack_reg, nack_next, oe_reg, oe_next;
  logic             scl_d_reg, sda_d_reg;
  logic             scl_rise, scl_fall, start_cond, stop_cond;
  logic             wr_stb, rd_stb, status_rd;
  logic [7:0]       enable_reg, enable_next;
  status_flags_type flags_reg, flags_next, set_vec;
  logic             detect_d_reg, detect_q, global_flag;
  logic             irq_n_reg, irq_n_next;

  // Pointer steps on every data byte written or read, not on the address or pointer byte
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    return 8'(p + 8'h01);
  endfunction

  // Bus pins and remote pin, idle high
  pin_filter #(.WIDTH(3), .INIT(3'b111)) u_pins (
    .clk   (clk),
    .reset (reset),
    .raw   ({remote_irq_in_n, sda_in, scl_in}),
    .clean (pins_clean)
  );
  assign scl_c    = pins_clean[0];
  assign sda_c    = pins_clean[1];
  assign remote_c = pins_clean[2];

  ident_rom #(.CAPABLE(PROTECT_CAPABLE)) u_ident (
    .clk   (clk),
    .reset (reset),
    .addr  (ptr_reg),
    .data  (rom_data)
  );

  // Bus edges and framing conditions
  assign scl_rise   = scl_c & ~scl_d_reg;
  assign scl_fall   = ~scl_c & scl_d_reg;
  assign start_cond = scl_c & scl_d_reg & sda_d_reg & ~sda_c;
  assign stop_cond  = scl_c & scl_d_reg & ~sda_d_reg & sda_c;

  // Read data selection by pointer
  always_comb begin
    unique case (ptr_reg)
      `OFF_IRQ_ENABLE: rd_data = enable_reg;
      `OFF_IRQ_STATUS: rd_data = status_byte;
      default:         rd_data = rom_data;
    endcase
  end

  // Bus target: address, pointer byte, then data with auto-increment
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    rw_next    = rw_reg;
    first_next = first_reg;
    nack_next  = nack_reg;
    wr_stb     = 1'b0;
    rd_stb     = 1'b0;
    if (start_cond) begin
      state_next = BUS_ADDR;
      cnt_next   = 4'h0;
    end else if (stop_cond) begin
      state_next = BUS_IDLE;
    end else begin
      unique case (state_reg)
        BUS_IDLE: begin
          state_next = BUS_IDLE;
        end
        BUS_ADDR, BUS_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_c};
            cnt_next   = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == `BYTE_BITS) begin
            state_next = BUS_ACK;
            if (state_reg == BUS_ADDR) begin
              rw_next    = shift_reg[0];
              first_next = ~shift_reg[0];
              if (shift_reg[7:1] != `DEV_ADDR) begin
                state_next = BUS_IDLE; // Not ours: stay off the bus
              end
            end else if (first_reg) begin
              ptr_next   = shift_reg;
              first_next = 1'b0;
            end else begin
              wr_stb   = 1'b1;
              ptr_next = ptr_step(ptr_reg);
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              rd_stb     = 1'b1;
              shift_next = rd_data;
              ptr_next   = ptr_step(ptr_reg);
              state_next = BUS_TX;
            end else begin
              state_next = BUS_RX;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            if (cnt_reg == `LAST_TX_BIT) begin
              state_next = BUS_TXACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              cnt_next   = 4'(cnt_reg + 4'h1);
            end
          end
        end
        BUS_TXACK: begin
          if (scl_rise) begin
            nack_next = sda_c;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_next = BUS_IDLE; // Master ends the read
            end else begin
              rd_stb     = 1'b1;
              shift_next = rd_data;
              ptr_next   = ptr_step(ptr_reg);
              cnt_next   = 4'h0;
              state_next = BUS_TX;
            end
          end
        end
        default: begin
          state_next = BUS_IDLE;
        end
      endcase
    end
    // Registered drive avoids glitches on the shared data line
    oe_next = (state_next == BUS_ACK) |
              ((state_next == BUS_TX) & ~shift_next[7]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= BUS_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      nack_reg  <= 1'b1;
      oe_reg    <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      first_reg <= first_next;
      nack_reg  <= nack_next;
      oe_reg    <= oe_next;
      scl_d_reg <= scl_c;
      sda_d_reg <= sda_c;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = oe_reg;

  // Event sources; detect may be held back until the receiver locks
  assign detect_q = rx_detect &
                    (~detect_waits_for_lock_sel | rx_lock);
  always_comb begin
    set_vec.indirect_done  = event_pulse.indirect_done;
    set_vec.rx_found       = detect_q & ~detect_d_reg;
    set_vec.remote_irq     = ~remote_c;
    set_vec.key_list_ready = event_pulse.key_list_ready;
    set_vec.rx_key_ready   = event_pulse.rx_key_ready;
    set_vec.auth_fail      = event_pulse.auth_fail;
    set_vec.auth_ok        = event_pulse.auth_ok;
  end

  // Global bit: each source gated by its enable
  assign global_flag = |(flags_reg & enable_reg[7:1]);
  assign status_byte = {flags_reg, global_flag};
  assign status_rd   = rd_stb & (ptr_reg == `OFF_IRQ_STATUS);

  // Flags and enables; a new event in the clearing read's cycle survives
  always_comb begin
    flags_next  = status_rd ? status_flags_type'(`RST_IRQ_STATUS)
                            : flags_reg;
    flags_next  = flags_next | set_vec;
    enable_next = enable_reg;
    if (wr_stb && ptr_reg == `OFF_IRQ_ENABLE) begin
      enable_next = shift_reg;
    end
    irq_n_next = ~(global_flag & enable_reg[`GLOBAL_BIT]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg    <= status_flags_type'(`RST_IRQ_STATUS);
      enable_reg   <= `RST_IRQ_ENABLE;
      detect_d_reg <= 1'b0;
      irq_n_reg    <= 1'b1;
    end else begin
      flags_reg    <= flags_next;
      enable_reg   <= enable_next;
      detect_d_reg <= detect_q;
      irq_n_reg    <= irq_n_next;
    end
  end

  assign irq_n_out = irq_n_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_status_clear: assert property (
    status_rd && set_vec == '0 |=> flags_reg == '0)
    else $error("status read did not clear flags");
  chk_flag_sticky: assert property (
    flags_reg.auth_ok && !status_rd |=> flags_reg.auth_ok [*1])
    else $error("pass flag dropped without a status read");
  chk_indirect_set: assert property (
    event_pulse.indirect_done |=> flags_reg.indirect_done)
    else $error("indirect done flag not set");
  chk_fail_set: assert property (
    event_pulse.auth_fail |=> flags_reg.auth_fail)
    else $error("failure flag not set");
  chk_remote_low: assert property (
    !remote_c |=> flags_reg.remote_irq)
    else $error("low remote pin did not set flag");
  chk_detect_wait: assert property (
    detect_waits_for_lock_sel && !rx_lock && !flags_reg.rx_found &&
    !status_rd |=> !flags_reg.rx_found)
    else $error("detect flagged before lock");
  chk_irq_raise: assert property (
    global_flag && enable_reg[`GLOBAL_BIT] |=> !irq_n_out)
    else $error("interrupt not raised");
  chk_irq_gate: assert property (
    !enable_reg[`GLOBAL_BIT] |=> irq_n_out)
    else $error("interrupt raised with global enable off");
  chk_enable_write: assert property (
    wr_stb && ptr_reg == `OFF_IRQ_ENABLE |=>
    enable_reg == $past(shift_reg) ##1 rd_data == enable_reg ||
    ptr_reg != `OFF_IRQ_ENABLE)
    else $error("enable write lost");
  chk_ident_byte: assert property (
    ptr_reg == `OFF_IDENT_2 [*2] |-> rom_data ==
    (PROTECT_CAPABLE ? `IDENT_2_YES : `IDENT_2_NO))
    else $error("capability byte wrong");

  cov_status_read: cover property (status_rd && global_flag);
  cov_enable_write: cover property (wr_stb && ptr_reg == `OFF_IRQ_ENABLE);
  cov_irq_active: cover property ($fell(irq_n_out));
endmodule

// [bus_host_model.sv]
// Host controller model: open-drain master on the serial control bus.
// Assumes the caller resolves the pulled-up data line from both drivers.
`timescale 1ns/1ps
`include "protect_irq_regs.svh"
module bus_host_model (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low,
  output logic      nack_seen
);
  // Phase length kept well above the target's pin filter lag
  localparam int PHASE = 12;

  initial begin
    scl       = 1'b1;
    sda_low   = 1'b0;
    nack_seen = 1'b0;
  end

  task automatic wait_phase();
    repeat (PHASE) @(negedge clk);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic bus_start();
    sda_low = 1'b0;
    wait_phase();
    scl = 1'b1;
    wait_phase();
    sda_low = 1'b1;
    wait_phase();
    scl = 1'b0;
    wait_phase();
  endtask

  // Stop: data rises while the clock is high, then the bus idles high
  task automatic bus_stop();
    sda_low = 1'b1;
    wait_phase();
    scl = 1'b1;
    wait_phase();
    sda_low = 1'b0;
    wait_phase();
  endtask

  // Data only moves a full phase after the clock fell, never beside it
  task automatic put_bit(input logic b);
    sda_low = ~b;
    wait_phase();
    scl = 1'b1;
    wait_phase();
    scl = 1'b0;
    wait_phase();
  endtask

  // Released line reads the pull-up unless the target pulls it low
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    wait_phase();
    scl = 1'b1;
    wait_phase();
    b = sda_line;
    scl = 1'b0;
    wait_phase();
  endtask

  task automatic write_byte(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    if (b) begin
      nack_seen = 1'b1;
    end
  endtask

  task automatic read_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1); // Single byte reads end with a not-acknowledge
  endtask

  task automatic reg_write(input logic [7:0] off, input logic [7:0] val);
    bus_start();
    write_byte({`DEV_ADDR, 1'b0});
    write_byte(off);
    write_byte(val);
    bus_stop();
  endtask

  task automatic reg_read(input logic [7:0] off, output logic [7:0] val);
    bus_start();
    write_byte({`DEV_ADDR, 1'b0});
    write_byte(off);
    bus_start();
    write_byte({`DEV_ADDR, 1'b1});
    read_byte(val);
    bus_stop();
  endtask
endmodule

// [content_protect_irq_ctrl_test.sv]
// Self-checking bench for the content-protection interrupt block.
// Assumes the host model as bus master and a pull-up on the data line.
`timescale 1ns/1ps
`include "protect_irq_regs.svh"
`define CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module content_protect_irq_ctrl_test;
  import protect_irq_pkg::*;

  typedef struct packed {
    logic [7:0]         en;
    protect_events_type ev;
    logic [7:0]         st;
    logic               irq_n;
  } row_type;

  // Stimulus and outputs
  logic               clk;
  logic               reset;
  logic               scl;
  logic               host_sda_low;
  logic               nack_seen;
  logic               sda_out;
  logic               sda_oe;
  protect_events_type event_pulse;
  logic               rx_detect;
  logic               rx_lock;
  logic               wait_sel;
  logic               remote_n;
  logic               irq_n_out;
  logic [7:0]         rd;
  int                 n_errors;
  int                 num_checks;
  int                 cycles;

  // Enable, one event, expected status and interrupt pin
  row_type rows [7] = '{
    '{8'h81, 5'h10, 8'h81, 1'b0},
    '{8'h11, 5'h08, 8'h11, 1'b0},
    '{8'h09, 5'h04, 8'h09, 1'b0},
    '{8'h05, 5'h02, 8'h05, 1'b0},
    '{8'h03, 5'h01, 8'h03, 1'b0},
    '{8'h02, 5'h01, 8'h03, 1'b1},
    '{8'h7f, 5'h10, 8'h80, 1'b1}
  };
  logic [7:0] ident [6] = '{`IDENT_0, `IDENT_1, `IDENT_2_YES,
                            `IDENT_3, `IDENT_4, `IDENT_5};

  // Open drain: either party pulling low wins over the pull-up
  wire sda_line = ~((sda_oe & ~sda_out) | host_sda_low);

  bus_host_model host (
    .clk       (clk),
    .sda_line  (sda_line),
    .scl       (scl),
    .sda_low   (host_sda_low),
    .nack_seen (nack_seen)
  );

  content_protect_irq_ctrl #(.PROTECT_CAPABLE(1'b1)) DUT (
    .clk                       (clk),
    .reset                     (reset),
    .scl_in                    (scl),
    .sda_in                    (sda_line),
    .sda_out                   (sda_out),
    .sda_oe                    (sda_oe),
    .event_pulse               (event_pulse),
    .rx_detect                 (rx_detect),
    .rx_lock                   (rx_lock),
    .detect_waits_for_lock_sel (wait_sel),
    .remote_irq_in_n           (remote_n),
    .irq_n_out                 (irq_n_out)
  );

  always #50 clk = ~clk;

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Ceiling well above the roughly 51k cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic read_check(input logic [7:0] off, input logic [7:0] exp);
    host.reg_read(off, rd);
    `CHECK(rd, exp)
  endtask

  task automatic pulse(input protect_events_type ev);
    event_pulse = ev;
    @(negedge clk);
    event_pulse = '0;
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    event_pulse = '0;
    rx_detect = 1'b0;
    rx_lock = 1'b0;
    wait_sel = 1'b0;
    remote_n = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk); // Pin filters settle before the first start
    `CHECK(irq_n_out, 1'b1)
    read_check(`OFF_IRQ_ENABLE, `RST_IRQ_ENABLE);
    read_check(`OFF_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      read_check(`OFF_IDENT_0 + 8'(i), ident[i]);
    end
    read_check(8'h10, `IDENT_NONE);
    // Status is read only; a write there must leave it untouched
    host.reg_write(`OFF_IRQ_STATUS, 8'hff);
    read_check(`OFF_IRQ_STATUS, 8'h00);
    host.reg_write(`OFF_IRQ_ENABLE, 8'hfe);
    read_check(`OFF_IRQ_ENABLE, 8'hfe);
    // Ordinary cases; irq lags the pulse by two cycles
    foreach (rows[i]) begin
      host.reg_write(`OFF_IRQ_ENABLE, rows[i].en);
      pulse(rows[i].ev);
      repeat (3) @(negedge clk);
      `CHECK(irq_n_out, rows[i].irq_n)
      read_check(`OFF_IRQ_STATUS, rows[i].st);
    end
    // Flag and pin hold until a status read, then drop
    host.reg_write(`OFF_IRQ_ENABLE, 8'h03);
    pulse(5'h01);
    repeat (40) @(negedge clk);
    `CHECK(irq_n_out, 1'b0)
    read_check(`OFF_IRQ_STATUS, 8'h03);
    repeat (3) @(negedge clk);
    `CHECK(irq_n_out, 1'b1)
    read_check(`OFF_IRQ_STATUS, 8'h00);
    // Detect waits for lock when the select bit is set
    host.reg_write(`OFF_IRQ_ENABLE, 8'h41);
    wait_sel = 1'b1;
    rx_detect = 1'b1;
    repeat (10) @(negedge clk);
    `CHECK(irq_n_out, 1'b1)
    rx_lock = 1'b1;
    repeat (4) @(negedge clk);
    `CHECK(irq_n_out, 1'b0)
    read_check(`OFF_IRQ_STATUS, 8'h41);
    // Without the select bit a new detect flags at once
    rx_detect = 1'b0;
    wait_sel = 1'b0;
    rx_lock = 1'b0;
    @(negedge clk);
    rx_detect = 1'b1;
    repeat (4) @(negedge clk);
    `CHECK(irq_n_out, 1'b0)
    read_check(`OFF_IRQ_STATUS, 8'h41);
    // Remote pin is active low and passes through its filter
    host.reg_write(`OFF_IRQ_ENABLE, 8'h21);
    remote_n = 1'b0;
    repeat (10) @(negedge clk);
    `CHECK(irq_n_out, 1'b0)
    remote_n = 1'b1;
    repeat (10) @(negedge clk);
    read_check(`OFF_IRQ_STATUS, 8'h21);
    read_check(`OFF_IRQ_STATUS, 8'h00);
    // Mid-run reset drops a pending flag, the enables and the pin
    rx_detect = 1'b0; // No detect edge may be left pending across reset
    host.reg_write(`OFF_IRQ_ENABLE, 8'h03);
    pulse(5'h01);
    repeat (3) @(negedge clk);
    `CHECK(irq_n_out, 1'b0)
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    `CHECK(irq_n_out, 1'b1)
    repeat (4) @(negedge clk);
    read_check(`OFF_IRQ_ENABLE, `RST_IRQ_ENABLE);
    read_check(`OFF_IRQ_STATUS, 8'h00);
    `CHECK(nack_seen, 1'b0)
    test_done();
  end
endmodule
